// file: hdl/tlc_cfg.svh
// Functional notes
// (R1) Software keeps reserved registers at their reset values and writes nothing else there.
// (R2) Writing one to the sleep request bit 7 sends the chip to sleep and the bit clears itself.
// (R3) Bits 6 and 5 are two modulation switch settings, each zero for ASK and one for FSK.
// (R4) The invert bit 3 inverts the encoded stream when one and passes it unchanged when zero.
// (R5) Codes 000..111: Manchester, diff Manch, bi-space, bi-mark, Miller, NRZ, PRBS, zero out; 111 here drives the invert bit value.
// (R6) The amplitude ramp enable bit 4 turns sloped ASK transitions on when one, off when zero.
`ifndef TLC_CFG_SVH
`define TLC_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define TLC_TXCFG2_IDX 8'h05
`define TLC_TXCFG2_ADDR 12'h014
`define TLC_TXCFG2_RST 8'h25
`define TLC_BIT_SLEEP 7
`define TLC_BIT_MOD_HI 6
`define TLC_BIT_MOD_LO 5
`define TLC_BIT_RAMP 4
`define TLC_BIT_INVERT 3
`define TLC_CODE_MSB 2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TLC_CLK_PERIOD_NS 10
`define TLC_HALF_BIT_NS 50000
`define TLC_HALF_BIT_CYCLES (`TLC_HALF_BIT_NS / `TLC_CLK_PERIOD_NS)
`define TLC_PRBS_SEED 9'h1FF
`define TLC_PRBS_TAP 4

`endif

// file: hdl/tlc_pkg.sv
package tlc_pkg;
    typedef enum logic [2:0] {
        CODE_MANCH,
        CODE_DIFF_MANCH,
        CODE_BIPHASE_SPACE,
        CODE_BIPHASE_MARK,
        CODE_MILLER,
        CODE_NRZ,
        CODE_PRBS,
        CODE_UNUSED
    } tlc_code_e;

    typedef struct packed {
        logic sleepRequest;
        logic modSwitchSettingHi;
        logic modSwitchSettingLo;
        logic ampRampEnable;
        logic invert;
        tlc_code_e lineCodeSelect;
    } tlc_cfg_s;
endpackage : tlc_pkg

// file: hdl/tlc_line_coder.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tlc_cfg.svh"

module tlc_line_coder
    import tlc_pkg::*;
#(
    parameter int HALF_BIT_CYC = `TLC_HALF_BIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic txEnable,
    input wire logic txData,
    input wire logic modSel,
    output logic txBitTaken,
    output logic txLineOut,
    output logic sleepEnter,
    output logic [1:0] modSwitchSetting,
    output logic ampRampEnable,
    output logic askSlopeOn
);

    // ----------------------------------------------------------------
    // APB slave and configuration register
    // ----------------------------------------------------------------
    tlc_cfg_s cfg_q, cfg_d;
    logic sleep_q, sleep_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic hit, wrEn;

    assign hit = (paddr == `TLC_TXCFG2_ADDR);
    assign wrEn = psel && penable && pwrite && hit && pstrb[0];
    assign pready = psel && penable;
    assign prdata = rdata_q;
    assign pslverr = pready && err_q;

    // Register next values, sleep bit never stored
    always_comb begin
        cfg_d = cfg_q;
        sleep_d = 1'b0;
        rdata_d = rdata_q;
        err_d = err_q;
        if (wrEn) begin
            cfg_d = tlc_cfg_s'(pwdata[`TLC_BIT_SLEEP:0]);
            cfg_d.sleepRequest = 1'b0;                   // [R2]
            sleep_d = pwdata[`TLC_BIT_SLEEP];            // [R2]
        end
        if (psel && !penable) begin
            err_d = !hit;
            rdata_d = hit ? {24'h000000, cfg_q} : 32'h00000000;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= tlc_cfg_s'(`TLC_TXCFG2_RST);
            sleep_q <= 1'b0;
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            sleep_q <= sleep_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // Configuration outputs; sleepEnter is a one-cycle pulse, askSlopeOn follows modSel
    assign sleepEnter = sleep_q;
    assign modSwitchSetting = {cfg_q.modSwitchSettingHi, cfg_q.modSwitchSettingLo}; // [R3]
    assign ampRampEnable = cfg_q.ampRampEnable;
    assign askSlopeOn = cfg_q.ampRampEnable && !modSwitchSetting[modSel]; // [R6]

    // ----------------------------------------------------------------
    // Half-bit divider
    // ----------------------------------------------------------------
    logic [31:0] halfCnt_q, halfCnt_d;
    logic halfTick;

    assign halfTick = txEnable && (halfCnt_q == 32'(HALF_BIT_CYC - 1));

    always_comb begin
        halfCnt_d = 32'h00000000;
        if (txEnable && !halfTick) begin
            halfCnt_d = halfCnt_q + 32'h00000001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            halfCnt_q <= 32'h00000000;
        end else begin
            halfCnt_q <= halfCnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Line encoder
    // ----------------------------------------------------------------
    logic phase_q, phase_d;
    logic level_q, level_d;
    logic bit_q, bit_d;
    logic prevBit_q, prevBit_d;
    logic [8:0] prbs_q, prbs_d;
    logic out_q, out_d;
    logic taken_q, taken_d;
    logic dat;

    assign dat = phase_q ? bit_q : txData;

    // Level for each half bit per code
    always_comb begin
        phase_d = phase_q;
        level_d = level_q;
        bit_d = bit_q;
        prevBit_d = prevBit_q;
        prbs_d = prbs_q;
        taken_d = 1'b0;
        if (halfTick) begin
            phase_d = !phase_q;
            if (!phase_q) begin
                bit_d = txData;
                taken_d = 1'b1;
            end else begin
                prevBit_d = bit_q;
            end
            unique case (cfg_q.lineCodeSelect)                                      // [R5]
                CODE_MANCH: level_d = phase_q ? !dat : dat;
                CODE_DIFF_MANCH: level_d = (phase_q || !dat) ? !level_q : level_q;
                CODE_BIPHASE_SPACE: level_d = (!phase_q || !dat) ? !level_q : level_q;
                CODE_BIPHASE_MARK: level_d = (!phase_q || dat) ? !level_q : level_q;
                CODE_MILLER: begin
                    if (phase_q) begin
                        level_d = dat ? !level_q : level_q;
                    end else begin
                        level_d = (!dat && !prevBit_q) ? !level_q : level_q;
                    end
                end
                CODE_NRZ: level_d = dat;
                CODE_PRBS: begin
                    level_d = dat ^ prbs_q[8];
                    if (phase_q) begin
                        prbs_d = {prbs_q[7:0], prbs_q[8] ^ prbs_q[`TLC_PRBS_TAP]};
                    end
                end
                CODE_UNUSED: level_d = 1'b0;
            endcase
        end
        if (!txEnable) begin
            phase_d = 1'b0;
        end
        out_d = halfTick ? (level_d ^ cfg_q.invert) : out_q;                      // [R4]
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 1'b0;
            level_q <= 1'b0;
            bit_q <= 1'b0;
            prevBit_q <= 1'b0;
            prbs_q <= `TLC_PRBS_SEED;
            out_q <= 1'b0;
            taken_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            level_q <= level_d;
            bit_q <= bit_d;
            prevBit_q <= prevBit_d;
            prbs_q <= prbs_d;
            out_q <= out_d;
            taken_q <= taken_d;
        end
    end

    assign txLineOut = out_q;
    assign txBitTaken = taken_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_sleep_pulse;
        @(posedge core_clk) disable iff (!rst_n)
        (wrEn && pwdata[`TLC_BIT_SLEEP]) |=> sleepEnter ##1 !sleepEnter;
    endproperty
    a_sleep_pulse: assert property (p_sleep_pulse) else $error("sleep pulse wrong"); // [R2]

    property p_sleep_reads_zero;
        @(posedge core_clk) disable iff (!rst_n)
        !prdata[`TLC_BIT_SLEEP];
    endproperty
    a_sleep_reads_zero: assert property (p_sleep_reads_zero) else $error("sleep bit stuck"); // [R2]

    property p_mod_setting;
        @(posedge core_clk) disable iff (!rst_n)
        wrEn |=> modSwitchSetting == $past(pwdata[`TLC_BIT_MOD_HI:`TLC_BIT_MOD_LO]);
    endproperty
    a_mod_setting: assert property (p_mod_setting) else $error("mod setting lost"); // [R3]

    property p_invert;
        @(posedge core_clk) disable iff (!rst_n)
        halfTick |=> txLineOut == (level_q ^ $past(cfg_q.invert));
    endproperty
    a_invert: assert property (p_invert) else $error("inversion wrong"); // [R4]

    property p_unused_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (halfTick && cfg_q.lineCodeSelect == CODE_UNUSED) |=> txLineOut == $past(cfg_q.invert);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused code not zero"); // [R5]

    property p_manch_mid;
        @(posedge core_clk) disable iff (!rst_n)
        (halfTick && phase_q && cfg_q.lineCodeSelect == CODE_MANCH && !wrEn)
            |=> txLineOut != $past(txLineOut);
    endproperty
    a_manch_mid: assert property (p_manch_mid) else $error("no mid-bit edge"); // [R5]

    property p_ramp;
        @(posedge core_clk) disable iff (!rst_n)
        askSlopeOn == (cfg_q.ampRampEnable
            && !(modSel ? cfg_q.modSwitchSettingHi : cfg_q.modSwitchSettingLo));
    endproperty
    a_ramp: assert property (p_ramp) else $error("slope gating wrong"); // [R6]

    property p_ramp_write;
        @(posedge core_clk) disable iff (!rst_n)
        wrEn |=> ampRampEnable == $past(pwdata[`TLC_BIT_RAMP]);
    endproperty
    a_ramp_write: assert property (p_ramp_write) else $error("ramp enable lost"); // [R6]

endmodule : tlc_line_coder

`default_nettype wire

// file: tb/tlc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Host side: raw transmit bits
// ----------------------------------------------------------------
module tlc_host_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic txBitTaken,
    output logic txData
);
    logic [15:0] pat_q;

    // Next bit shown right after the current one was taken
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pat_q <= 16'hB2E9;
        end else if (txBitTaken) begin
            pat_q <= {pat_q[14:0], pat_q[15]};
        end
    end
    assign txData = pat_q[15];
endmodule : tlc_host_model

`default_nettype wire

// file: tb/tx_line_coding_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlc_cfg.svh"

module tx_line_coding_config_bench
    import tlc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic txEnable = 1'b0;
    logic modSel = 1'b0;
    wire logic pready, pslverr, txData, txBitTaken, txLineOut, sleepEnter;
    wire logic ampRampEnable, askSlopeOn;
    wire logic [31:0] prdata;
    wire logic [1:0] modSwitchSetting;
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int samplesChecked = 0;
    int cycles = 0;
    localparam logic [11:0] ADDR = `TLC_TXCFG2_ADDR;
    localparam int HALF = 4;
    // Reference coder state, carried across codes like the encoder's own
    logic refLvl = 1'b0;
    logic refPrev = 1'b0;
    logic [8:0] refPrbs = `TLC_PRBS_SEED;

    tlc_line_coder #(.HALF_BIT_CYC(HALF)) dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .txEnable(txEnable),
        .txData(txData), .modSel(modSel), .txBitTaken(txBitTaken), .txLineOut(txLineOut),
        .sleepEnter(sleepEnter), .modSwitchSetting(modSwitchSetting),
        .ampRampEnable(ampRampEnable), .askSlopeOn(askSlopeOn));
    tlc_host_model host (.core_clk(core_clk), .rst_n(rst_n), .txBitTaken(txBitTaken),
        .txData(txData));

    // Clock and hang guard
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            completeRun();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Both line chips of each taken bit against a reference coder
    task automatic run_code(input logic [3:0] cfg);
        logic b;
        logic l1;
        logic l2;
        apb(1'b1, ADDR, {28'h0, cfg}, 4'h1);
        txEnable <= 1'b1;
        repeat (6) begin
            do @(negedge core_clk); while (txBitTaken !== 1'b1);
            b = txData;
            // First half of the bit
            case (tlc_code_e'(cfg[2:0]))
                CODE_MANCH, CODE_NRZ: l1 = b;
                CODE_DIFF_MANCH: l1 = b ? refLvl : !refLvl;
                CODE_BIPHASE_SPACE, CODE_BIPHASE_MARK: l1 = !refLvl;
                CODE_MILLER: l1 = (!b && !refPrev) ? !refLvl : refLvl;
                CODE_PRBS: l1 = b ^ refPrbs[8];
                default: l1 = 1'b0;
            endcase
            chk(txLineOut, l1 ^ cfg[3]);
            repeat (HALF) @(negedge core_clk);
            // Second half of the bit
            case (tlc_code_e'(cfg[2:0]))
                CODE_MANCH: l2 = !b;
                CODE_DIFF_MANCH: l2 = !l1;
                CODE_BIPHASE_SPACE: l2 = b ? l1 : !l1;
                CODE_BIPHASE_MARK, CODE_MILLER: l2 = b ? !l1 : l1;
                CODE_NRZ: l2 = b;
                CODE_PRBS: l2 = b ^ refPrbs[8];
                default: l2 = 1'b0;
            endcase
            chk(txLineOut, l2 ^ cfg[3]);
            if (cfg[2:0] == CODE_PRBS) begin
                refPrbs = {refPrbs[7:0], refPrbs[8] ^ refPrbs[`TLC_PRBS_TAP]};
            end
            refLvl = l2;
            refPrev = b;
        end
        @(posedge core_clk);
        txEnable <= 1'b0;
    endtask : run_code

    task automatic completeRun();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : completeRun

    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR, 32'h0, 4'h0);
        chk(rd, 32'h25);
        chk({modSwitchSetting, ampRampEnable}, 3'b010);
        $display("Test reset done");
        apb(1'b1, ADDR, 32'hF8, 4'h1);
        @(negedge core_clk) chk(sleepEnter, 1'b1);
        @(negedge core_clk) chk(sleepEnter, 1'b0);
        apb(1'b0, ADDR, 32'h0, 4'h0);
        chk(rd, 32'h78);
        chk(err, 1'b0);
        chk({modSwitchSetting, ampRampEnable, askSlopeOn}, 4'hE);
        apb(1'b1, ADDR, 32'h50, 4'h1);
        @(negedge core_clk) chk(askSlopeOn, 1'b1);
        @(posedge core_clk) modSel <= 1'b1;
        @(negedge core_clk) chk(askSlopeOn, 1'b0);
        apb(1'b1, ADDR, 32'h0, 4'h0);
        apb(1'b1, 12'h018, 32'h0, 4'h1);
        chk(err, 1'b1);
        apb(1'b0, ADDR, 32'h0, 4'h0);
        chk(rd, 32'h50);
        $display("Test register done");
        for (int i = 0; i < 16; i++) begin
            run_code(i[3:0]);
        end
        $display("Test coding done");
        completeRun();
    end
endmodule : tx_line_coding_config_bench

`default_nettype wire
